// ### hdl/uart_autoflow.sv
// fifo serial port with automatic request/clear-to-send flow control
// assumes serial inputs synchronous to core_clk and a classic wishbone master
//
// Overview of operation
// - baud divider 1..65535 yields 16x tick
// - sixteen-deep fifos, receive entries carry error bits
// - automatic flow control only in fifo mode
// - autoflow plus request bit enables both directions
// - autoflow without request bit: transmit gating only
// - receive trigger selectable 1, 4, 8, 14
// - low triggers drop request at trigger level
// - low triggers raise request only when emptied
// - receiver still accepts one extra character
// - trigger 14 drops request at 16th character
// - trigger 14 raises request when space free
// - trigger 14: full fifo, first read raises request
// - clear-to-send checked before each new character
// - transmission resumes when clear-to-send returns low
// - no modem interrupt while transmit gating active
// - without gating, transmit regardless of clear-to-send
// - status shows clear-to-send level and change flag
module uart_autoflow
   import uart_flow_pkg::*;
#(
   parameter int unsigned DEPTH = uart_flow_pkg::FIFO_DEPTH
) (
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   input  wire uart_flow_pkg::wb_req_type wb_req,
   output logic                           wb_ack_o,
   output logic [31:0]                    wb_dat_o,
   input  wire logic                      serial_input_line,
   input  wire logic                      cts_n,
   output logic                           tx_line,
   output logic                           rts_n,
   output logic                           irq
);
   import uart_flow_pkg::*;

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] LAST_CNT = CW'(DEPTH - 1);

   logic              fifo_en_reg;
   logic [1:0]        trig_sel_reg;
   logic              modem_req_reg;
   logic              afe_reg;
   logic [15:0]       divisor_reg;
   logic [IRQ_W-1:0]  irq_stat_reg;
   logic [IRQ_W-1:0]  irq_mask_reg;
   logic              dcts_reg;
   logic              cts_prev_reg;
   logic [15:0]       baud_cnt_reg;
   logic              baud_tick_reg;
   logic              low_block_reg;

   // bus decode: request acted on in the cycle before ack rises
   logic bus_go;
   logic bus_wr;
   logic bus_rd;
   assign bus_go = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   assign bus_wr = bus_go & wb_req.we;
   assign bus_rd = bus_go & ~wb_req.we;

   logic wr_data;
   logic rd_data;
   logic rd_mstat;
   assign wr_data  = bus_wr & wb_req.sel[0] & (wb_req.adr == ADR_DATA);
   assign rd_data  = bus_rd & (wb_req.adr == ADR_DATA);
   assign rd_mstat = bus_rd & (wb_req.adr == ADR_MSTAT);

   // fifo storage
   logic [DATA_W-1:0] tx_mem [DEPTH];
   rx_entry_type      rx_mem [DEPTH];
   logic [PW-1:0]     tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
   logic [CW-1:0]     tx_cnt_reg, rx_cnt_reg;

   // character mode behaves as a single holding register
   logic tx_full;
   logic rx_full;
   assign tx_full = fifo_en_reg ? (tx_cnt_reg == FULL_CNT) : (tx_cnt_reg != '0);
   assign rx_full = fifo_en_reg ? (rx_cnt_reg == FULL_CNT) : (rx_cnt_reg != '0);

   tx_state_type      tx_state_reg;
   rx_state_type      rx_state_reg;
   logic              cts_gate;
   logic              tx_pop;
   logic              tx_push;
   logic              rx_pop;
   logic              rx_push_reg;
   rx_entry_type      rx_entry_reg;
   logic              rx_ovr;

   assign cts_gate = fifo_en_reg & afe_reg;
   // clear-to-send is looked at only when a new character would start
   assign tx_pop  = (tx_state_reg == TX_IDLE) && (tx_cnt_reg != '0)
                    && (!cts_gate || !cts_n);
   assign tx_push = wr_data & ~tx_full;
   assign rx_pop  = rd_data & (rx_cnt_reg != '0);
   assign rx_ovr  = rx_push_reg & rx_full;

   // configuration registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fifo_en_reg   <= 1'b0;
         trig_sel_reg  <= TRIG_RESET;
         modem_req_reg <= 1'b0;
         afe_reg       <= 1'b0;
         divisor_reg   <= DIV_RESET;
         irq_mask_reg  <= IMASK_RESET;
      end else if (bus_wr) begin
         if (wb_req.sel[0]) begin
            unique case (wb_req.adr)
               ADR_FIFO: begin
                  fifo_en_reg  <= wb_req.dat[FIFO_EN_BIT];
                  trig_sel_reg <= wb_req.dat[FIFO_TRIG_LSB +: 2];
               end
               ADR_MODEM: begin
                  modem_req_reg <= wb_req.dat[MODEM_REQ_BIT];
                  afe_reg       <= wb_req.dat[MODEM_AFE_BIT];
               end
               ADR_DIV:   divisor_reg[7:0] <= wb_req.dat[7:0];
               ADR_IMASK: irq_mask_reg <= wb_req.dat[IRQ_W-1:0];
               default: ;
            endcase
         end
         if (wb_req.sel[1] && wb_req.adr == ADR_DIV) begin
            divisor_reg[15:8] <= wb_req.dat[15:8];
         end
      end
   end

   // baud divider: one tick per divisor clocks, zero acts as one
   logic [15:0] div_last;
   assign div_last = (divisor_reg == '0) ? '0 : divisor_reg - 16'h0001;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         baud_cnt_reg  <= '0;
         baud_tick_reg <= 1'b0;
      end else if (baud_cnt_reg >= div_last) begin
         baud_cnt_reg  <= '0;
         baud_tick_reg <= 1'b1;
      end else begin
         baud_cnt_reg  <= baud_cnt_reg + 16'h0001;
         baud_tick_reg <= 1'b0;
      end
   end

   // transmit fifo
   always_ff @(posedge core_clk) begin
      if (tx_push) begin
         tx_mem[tx_wp_reg] <= wb_req.dat[DATA_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_wp_reg  <= '0;
         tx_rp_reg  <= '0;
         tx_cnt_reg <= '0;
      end else begin
         if (tx_push) begin
            tx_wp_reg <= PW'(tx_wp_reg + 1'b1);
         end
         if (tx_pop) begin
            tx_rp_reg <= PW'(tx_rp_reg + 1'b1);
         end
         if (tx_push && !tx_pop) begin
            tx_cnt_reg <= CW'(tx_cnt_reg + 1'b1);
         end else if (tx_pop && !tx_push) begin
            tx_cnt_reg <= CW'(tx_cnt_reg - 1'b1);
         end
      end
   end

   // transmitter, 8 data bits, one stop bit
   logic [3:0]        tx_sub_reg;
   logic [2:0]        tx_bit_reg;
   logic [DATA_W-1:0] tx_shift_reg;
   logic              tx_bit_end;
   assign tx_bit_end = baud_tick_reg && (tx_sub_reg == 4'(OVERSAMPLE - 1));

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_state_reg <= TX_IDLE;
         tx_sub_reg   <= '0;
         tx_bit_reg   <= '0;
         tx_shift_reg <= '0;
         tx_line      <= 1'b1;
      end else begin
         if (baud_tick_reg) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
         end
         unique case (tx_state_reg)
            TX_IDLE: begin
               tx_line <= 1'b1;
               if (tx_pop) begin
                  tx_state_reg <= TX_START;
                  tx_shift_reg <= tx_mem[tx_rp_reg];
                  tx_sub_reg   <= '0;
                  tx_line      <= 1'b0;
               end
            end
            TX_START: if (tx_bit_end) begin
               tx_state_reg <= TX_DATA;
               tx_bit_reg   <= '0;
               tx_line      <= tx_shift_reg[0];
            end
            TX_DATA: if (tx_bit_end) begin
               if (tx_bit_reg == 3'h7) begin
                  tx_state_reg <= TX_STOP;
                  tx_line      <= 1'b1;
               end else begin
                  tx_bit_reg   <= tx_bit_reg + 3'h1;
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_line      <= tx_shift_reg[1];
               end
            end
            // a started character always finishes its stop bit
            TX_STOP: if (tx_bit_end) begin
               tx_state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   // receiver, samples each bit in its middle
   logic              rx_line_reg;
   logic [3:0]        rx_sub_reg;
   logic [2:0]        rx_bit_reg;
   logic [DATA_W-1:0] rx_shift_reg;
   logic              rx_in_data;
   assign rx_in_data = (rx_state_reg == RX_DATA && rx_bit_reg != '0)
                       || rx_state_reg == RX_STOP;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_line_reg  <= 1'b1;
         rx_state_reg <= RX_IDLE;
         rx_sub_reg   <= '0;
         rx_bit_reg   <= '0;
         rx_shift_reg <= '0;
         rx_push_reg  <= 1'b0;
         rx_entry_reg <= '0;
      end else begin
         rx_line_reg <= serial_input_line;
         rx_push_reg <= 1'b0;
         if (baud_tick_reg) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
         end
         unique case (rx_state_reg)
            RX_IDLE: if (!rx_line_reg) begin
               rx_state_reg <= RX_START;
               rx_sub_reg   <= '0;
            end
            RX_START: if (baud_tick_reg && rx_sub_reg == 4'(HALF_BIT - 1)) begin
               rx_sub_reg   <= '0;
               rx_bit_reg   <= '0;
               // a start bit gone high by its middle was noise
               rx_state_reg <= rx_line_reg ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (baud_tick_reg && rx_sub_reg == 4'(OVERSAMPLE - 1)) begin
               rx_shift_reg <= {rx_line_reg, rx_shift_reg[DATA_W-1:1]};
               rx_bit_reg   <= rx_bit_reg + 3'h1;
               if (rx_bit_reg == 3'h7) begin
                  rx_state_reg <= RX_STOP;
               end
            end
            RX_STOP: if (baud_tick_reg && rx_sub_reg == 4'(OVERSAMPLE - 1)) begin
               rx_state_reg       <= RX_IDLE;
               rx_push_reg        <= 1'b1;
               rx_entry_reg.data  <= rx_shift_reg;
               rx_entry_reg.err   <= {(rx_shift_reg == '0) && !rx_line_reg,
                                      !rx_line_reg, 1'b0};
            end
         endcase
      end
   end

   // receive fifo; a character arriving when full is dropped
   always_ff @(posedge core_clk) begin
      if (rx_push_reg && !rx_full) begin
         rx_mem[rx_wp_reg] <= rx_entry_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_wp_reg  <= '0;
         rx_rp_reg  <= '0;
         rx_cnt_reg <= '0;
      end else begin
         if (rx_push_reg && !rx_full) begin
            rx_wp_reg <= PW'(rx_wp_reg + 1'b1);
         end
         if (rx_pop) begin
            rx_rp_reg <= PW'(rx_rp_reg + 1'b1);
         end
         if (rx_push_reg && !rx_full && !rx_pop) begin
            rx_cnt_reg <= CW'(rx_cnt_reg + 1'b1);
         end else if (rx_pop && !(rx_push_reg && !rx_full)) begin
            rx_cnt_reg <= CW'(rx_cnt_reg - 1'b1);
         end
      end
   end

   // request-to-send
   logic          auto_rts;
   logic          trig14;
   logic [CW-1:0] trig_cnt;
   logic          trig_hit;
   logic          t14_block;
   assign auto_rts  = fifo_en_reg & afe_reg & modem_req_reg;
   assign trig14    = (trig_sel_reg == TRIG_CODE_14);
   assign trig_hit  = (rx_cnt_reg >= trig_cnt);
   assign t14_block = (rx_cnt_reg == FULL_CNT)
                      || (rx_cnt_reg == LAST_CNT && rx_in_data);

   always_comb begin
      unique case (trig_sel_reg)
         2'h0: trig_cnt = CW'(TRIG_0);
         2'h1: trig_cnt = CW'(TRIG_1);
         2'h2: trig_cnt = CW'(TRIG_2);
         2'h3: trig_cnt = CW'(TRIG_3);
      endcase
   end

   // once tripped, held until the fifo has been read empty
   always_ff @(posedge core_clk) begin
      if (sys_rst || !auto_rts || trig14) begin
         low_block_reg <= 1'b0;
      end else if (trig_hit) begin
         low_block_reg <= 1'b1;
      end else if (rx_cnt_reg == '0) begin
         low_block_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rts_n <= 1'b1;
      end else if (!auto_rts) begin
         rts_n <= ~modem_req_reg;
      end else if (trig14) begin
         rts_n <= t14_block;
      end else begin
         rts_n <= low_block_reg | trig_hit;
      end
   end

   // modem status: change flag, set wins over the read that clears it
   logic cts_change;
   assign cts_change = (cts_n != cts_prev_reg);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cts_prev_reg <= 1'b1;
         dcts_reg     <= 1'b0;
      end else begin
         cts_prev_reg <= cts_n;
         if (cts_change) begin
            dcts_reg <= 1'b1;
         end else if (rd_mstat) begin
            dcts_reg <= 1'b0;
         end
      end
   end

   // interrupts: sticky, write one to clear, new event wins
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clear;
   always_comb begin
      irq_event            = '0;
      irq_event[IRQ_RX]    = rx_push_reg && !rx_full && (rx_cnt_reg + 1'b1 >= trig_cnt);
      irq_event[IRQ_TX]    = tx_pop && (tx_cnt_reg == CW'(1));
      irq_event[IRQ_MODEM] = cts_change && !cts_gate;
      irq_event[IRQ_OVR]   = rx_ovr;
      irq_clear = '0;
      if (bus_wr && wb_req.sel[0] && wb_req.adr == ADR_ISTAT) begin
         irq_clear = wb_req.dat[IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_stat_reg <= '0;
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
         irq          <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // register read and ack; unmapped addresses read zero
   logic [31:0] rd_val;
   always_comb begin
      rd_val = '0;
      unique case (wb_req.adr)
         ADR_DATA: begin
            rd_val[DATA_W-1:0]          = rx_mem[rx_rp_reg].data;
            rd_val[DATA_ERR_LSB +: ERR_W] = rx_mem[rx_rp_reg].err;
         end
         ADR_FIFO: begin
            rd_val[FIFO_EN_BIT]          = fifo_en_reg;
            rd_val[FIFO_TRIG_LSB +: 2]   = trig_sel_reg;
         end
         ADR_MODEM: begin
            rd_val[MODEM_REQ_BIT] = modem_req_reg;
            rd_val[MODEM_AFE_BIT] = afe_reg;
         end
         ADR_MSTAT: begin
            rd_val[MSTAT_CTS_BIT]  = ~cts_n;
            rd_val[MSTAT_DCTS_BIT] = dcts_reg;
         end
         ADR_DIV:   rd_val[15:0] = divisor_reg;
         ADR_ISTAT: rd_val[IRQ_W-1:0] = irq_stat_reg;
         ADR_IMASK: rd_val[IRQ_W-1:0] = irq_mask_reg;
         ADR_LEVEL: begin
            rd_val[CW-1:0]             = rx_cnt_reg;
            rd_val[LEVEL_TX_LSB +: CW] = tx_cnt_reg;
            rd_val[LEVEL_RTS_BIT]      = ~rts_n;
         end
         default: ;
      endcase
      if (rd_data && rx_cnt_reg == '0) begin
         rd_val = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_go;
         wb_dat_o <= bus_rd ? rd_val : '0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_sixteenth_arriving;
      auto_rts && trig14 && rx_cnt_reg == LAST_CNT ##0 rx_in_data;
   endsequence

   sequence s_tx_blocked;
      cts_gate && cts_n && tx_state_reg == TX_IDLE && tx_cnt_reg != '0;
   endsequence

   AST_BAUD_PERIOD: assert property (baud_tick_reg |-> baud_cnt_reg == '0)
      else $error("baud tick without counter restart");
   AST_RTS_PLAIN: assert property (!auto_rts |=> rts_n == ~$past(modem_req_reg))
      else $error("request output does not follow modem bit");
   AST_LOW_TRIG: assert property (auto_rts && !trig14 && trig_hit |=> rts_n)
      else $error("request not dropped at trigger level");
   AST_LOW_HOLD: assert property (auto_rts && !trig14 && low_block_reg && rx_cnt_reg != '0
                                  ##1 auto_rts && !trig14 |=> rts_n)
      else $error("request raised before fifo emptied");
   AST_T14_OFF: assert property (s_sixteenth_arriving |=> rts_n)
      else $error("request not dropped on sixteenth character");
   AST_T14_ON: assert property (auto_rts && trig14 && !t14_block |=> !rts_n)
      else $error("request not raised with room free");
   AST_T14_READ: assert property (auto_rts && trig14 && rx_cnt_reg == FULL_CNT && rx_pop
                                  ##1 auto_rts && trig14 && !rx_in_data |=> !rts_n)
      else $error("read of full fifo did not raise request");
   AST_CTS_HOLD: assert property (s_tx_blocked |=> tx_state_reg == TX_IDLE)
      else $error("character started with clear-to-send inactive");
   AST_NO_GATE: assert property (!cts_gate && tx_state_reg == TX_IDLE && tx_cnt_reg != '0
                                 |=> tx_state_reg == TX_START && !tx_line)
      else $error("ungated transmitter did not start");
   AST_RESUME: assert property (s_tx_blocked ##1 cts_gate && !cts_n |=> tx_state_reg == TX_START)
      else $error("transmitter did not resume");
   AST_NO_MODEM_IRQ: assert property (cts_gate && !irq_stat_reg[IRQ_MODEM]
                                      |=> !irq_stat_reg[IRQ_MODEM])
      else $error("modem interrupt raised while gating");
   AST_DCTS: assert property (cts_change |=> dcts_reg [*2] or (dcts_reg ##1 $past(rd_mstat)))
      else $error("clear-to-send change not flagged");

endmodule : uart_autoflow

// ### hdl/uart_flow_pkg.sv
// constants, register map and carrier types for the autoflow serial port
// assumes one clock domain and a classic wishbone master with 32-bit data
package uart_flow_pkg;

   localparam int unsigned DATA_W     = 8;
   localparam int unsigned ERR_W      = 3;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned HALF_BIT   = 8;

   // byte addresses of the word-aligned registers
   localparam logic [7:0] ADR_DATA   = 8'h00;
   localparam logic [7:0] ADR_FIFO   = 8'h04;
   localparam logic [7:0] ADR_MODEM  = 8'h08;
   localparam logic [7:0] ADR_MSTAT  = 8'h0C;
   localparam logic [7:0] ADR_DIV    = 8'h10;
   localparam logic [7:0] ADR_ISTAT  = 8'h14;
   localparam logic [7:0] ADR_IMASK  = 8'h18;
   localparam logic [7:0] ADR_LEVEL  = 8'h1C;

   // field positions
   localparam int unsigned FIFO_EN_BIT   = 0;
   localparam int unsigned FIFO_TRIG_LSB = 6;
   localparam int unsigned MODEM_REQ_BIT = 1;
   localparam int unsigned MODEM_AFE_BIT = 5;
   localparam int unsigned MSTAT_DCTS_BIT = 0;
   localparam int unsigned MSTAT_CTS_BIT  = 4;
   localparam int unsigned LEVEL_TX_LSB   = 8;
   localparam int unsigned LEVEL_RTS_BIT  = 16;
   localparam int unsigned DATA_ERR_LSB   = 8;

   // interrupt status / mask layout
   localparam int unsigned IRQ_W      = 4;
   localparam int unsigned IRQ_RX    = 0;
   localparam int unsigned IRQ_TX    = 1;
   localparam int unsigned IRQ_MODEM = 2;
   localparam int unsigned IRQ_OVR   = 3;

   // receive trigger levels, selected by a two-bit code
   localparam int unsigned TRIG_0 = 1;
   localparam int unsigned TRIG_1 = 4;
   localparam int unsigned TRIG_2 = 8;
   localparam int unsigned TRIG_3 = 14;
   localparam logic [1:0]  TRIG_CODE_14 = 2'h3;

   // reset values
   localparam logic [15:0] DIV_RESET   = 16'h0001;
   localparam logic [1:0]  TRIG_RESET  = 2'h0;
   localparam logic [IRQ_W-1:0] IMASK_RESET = 4'h0;

   typedef struct packed {
      logic [ERR_W-1:0]  err;   // break, framing, parity
      logic [DATA_W-1:0] data;
   } rx_entry_type;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_type;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA  = 4'b0100,
      TX_STOP  = 4'b1000
   } tx_state_type;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } rx_state_type;

endpackage : uart_flow_pkg

// ### testbench/remote_uart.sv
// remote serial partner: 8n1 sender and receiver, flow control on rts_n/cts_n
// assumes the port runs with divisor 1, so one bit lasts 16 core_clk cycles
module remote_uart (
   input  wire logic       core_clk,
   input  wire logic       tx_line,
   input  wire logic       rts_n,
   input  wire logic       stop_req,
   output logic            serial_input_line,
   output logic            cts_n,
   output logic [7:0]      got_byte,
   output int              got_count
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT_CYC = 16;
   logic rx_busy;
   initial begin
      serial_input_line = 1'b1;
      cts_n = 1'b1;
      rx_busy = 1'b0;
      got_count = 0;
      got_byte = 8'h00;
   end
   // hold-off moves only while the receiver is idle, from the middle of a stop bit on
   always @(posedge core_clk) if (!rx_busy) cts_n <= stop_req;
   // obey off lets one late character through, as a slow sender would
   task automatic send(input logic [7:0] b, input bit obey);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      if (obey) while (rts_n !== 1'b0) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         serial_input_line <= f[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
   endtask : send
   always begin
      @(negedge tx_line);
      rx_busy = 1'b1;
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         got_byte[i] = tx_line;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      got_count++;
      rx_busy = 1'b0;
   end
endmodule : remote_uart

// ### testbench/tb_top.sv
// self-checking bench for the autoflow serial port with a remote partner
// assumes divisor left at its reset value of 1
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_flow_pkg::*;
   logic        core_clk, sys_rst, stop_req, wb_ack_o, tx_line, rts_n, irq;
   logic        serial_input_line, cts_n;
   logic [31:0] wb_dat_o, v;
   logic [7:0]  got_byte, b;
   wb_req_type  wb_req;
   int          got_count, fail_count, compares, cycles, trig;
   logic [7:0]  sent_q[$], tx_q[$];

   uart_autoflow dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .wb_req(wb_req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .serial_input_line(serial_input_line),
      .cts_n(cts_n), .tx_line(tx_line), .rts_n(rts_n), .irq(irq));
   remote_uart partner_u (.core_clk(core_clk), .tx_line(tx_line), .rts_n(rts_n),
      .stop_req(stop_req), .serial_input_line(serial_input_line), .cts_n(cts_n),
      .got_byte(got_byte), .got_count(got_count));

   task automatic conclude();
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] d);
      @(posedge core_clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
      // data taken at the very edge that samples ack high
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      d = wb_dat_o;
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb(1'b1, adr, dat, d);
   endtask : wr
   task automatic rts_is(input logic exp);
      repeat (2) @(negedge core_clk);
      check({31'h0, rts_n}, {31'h0, exp});
   endtask : rts_is
   task automatic push_rx(input bit obey);
      b = 8'($urandom);
      sent_q.push_back(b);
      partner_u.send(b, obey);
      repeat (24) @(posedge core_clk);
   endtask : push_rx
   task automatic wait_tx(input int n);
      for (int w = 0; w < 1000 && got_count < n; w++) @(posedge core_clk);
      check(32'(got_count), 32'(n));
   endtask : wait_tx

   always @(got_count) if (got_count > 0) check({24'h0, got_byte}, {24'h0, tx_q.pop_front()});
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // whole run needs about 7200 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      wb_req = '0;
      sys_rst = 1'b1;
      stop_req = 1'b0;
      cycles = 0;
      void'($urandom(32'h67e9));
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      check({29'h0, rts_n, tx_line, irq}, 32'h0000_0006);
      wb(1'b0, ADR_DIV, 32'h0, v);
      check(v, 32'h0000_0001);
      wb(1'b0, 8'h20, 32'h0, v);
      check(v, 32'h0000_0000);
      wr(ADR_MODEM, 32'h0000_0002);
      rts_is(1'b0);
      wr(ADR_MODEM, 32'h0000_0022);
      push_rx(1'b1);
      rts_is(1'b0);
      wb(1'b0, ADR_DATA, 32'h0, v);
      check(v, {24'h0, sent_q.pop_front()});
      // a full sixteen-entry fill stands in for level 14
      for (int c = 0; c < 4; c++) begin
         trig = (c == 3) ? 16 : (c == 2) ? 8 : (c == 1) ? 4 : 1;
         wr(ADR_FIFO, 32'(1 + (c << 6)));
         wr(ADR_MODEM, 32'h0000_0022);
         for (int k = 1; k <= trig; k++) begin
            push_rx(1'b1);
            rts_is(k >= trig);
         end
         if (c < 3) push_rx(1'b0);
         while (sent_q.size() > 0) begin
            wb(1'b0, ADR_DATA, 32'h0, v);
            check(v, {24'h0, sent_q.pop_front()});
            rts_is(c < 3 && sent_q.size() != 0);
         end
      end
      wr(ADR_IMASK, 32'h0000_0002);
      // drop events left by the receive tests and the cts change after reset
      wr(ADR_ISTAT, 32'h0000_000f);
      wr(ADR_MODEM, 32'h0000_0020);
      stop_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      wb(1'b0, ADR_MSTAT, 32'h0, v);
      for (int k = 0; k < 2; k++) begin
         b = 8'($urandom);
         tx_q.push_back(b);
         wr(ADR_DATA, {24'h0, b});
      end
      repeat (300) @(posedge core_clk);
      check({tx_line, 31'(got_count)}, 32'h8000_0000);
      stop_req <= 1'b0;
      wait_tx(2);
      wb(1'b0, ADR_MSTAT, 32'h0, v);
      check(v, 32'h0000_0011);
      wb(1'b0, ADR_MSTAT, 32'h0, v);
      check(v, 32'h0000_0010);
      wb(1'b0, ADR_ISTAT, 32'h0, v);
      check(v & 32'h0000_0006, 32'h0000_0002);
      check({31'h0, irq}, 32'h0000_0001);
      wr(ADR_ISTAT, 32'h0000_0002);
      wr(ADR_IMASK, 32'h0000_0000);
      @(negedge core_clk);
      check({31'h0, irq}, 32'h0000_0000);
      wr(ADR_MODEM, 32'h0000_0000);
      stop_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      b = 8'($urandom);
      tx_q.push_back(b);
      wr(ADR_DATA, {24'h0, b});
      wait_tx(3);
      wb(1'b0, ADR_ISTAT, 32'h0, v);
      check({29'h0, v[2:1], irq}, 32'h0000_0006);
      conclude();
   end
endmodule : tb_top
